// file: common/irq_pkg.sv
// constants, register map and carrier types of the interrupt controller
package irq_pkg;

	// ----------------------------------------------------------------
	// register map, byte addresses on the wishbone bus
	// ----------------------------------------------------------------
	localparam int REG_COUNT = 8;
	localparam logic [4:0] OFS_SUPPLY_MONITOR_CONTROL = 5'h00;
	localparam logic [4:0] OFS_PIN_EDGE_SELECT = 5'h04;
	localparam logic [4:0] OFS_PRIMARY_IRQ_CTRL_0 = 5'h08;
	localparam logic [4:0] OFS_PRIMARY_IRQ_CTRL_1 = 5'h0C;
	localparam logic [4:0] OFS_PRIMARY_IRQ_CTRL_2 = 5'h10;
	localparam logic [4:0] OFS_SHARED_IRQ_GROUP_0 = 5'h14;
	localparam logic [4:0] OFS_SHARED_IRQ_GROUP_1 = 5'h18;
	localparam logic [4:0] OFS_SHARED_IRQ_GROUP_2 = 5'h1C;

	// register indices (byte address / 4)
	localparam int IDX_MON = 0;
	localparam int IDX_EDGE = 1;
	localparam int IDX_PRI0 = 2;
	localparam int IDX_PRI1 = 3;
	localparam int IDX_PRI2 = 4;
	localparam int IDX_GRP0 = 5;
	localparam int IDX_GRP1 = 6;
	localparam int IDX_GRP2 = 7;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int BIT_LOW_SUPPLY_STATUS = 5;
	localparam int BIT_SUPPLY_MONITOR_ON = 4;
	localparam int BIT_THRESHOLD_LSB = 0;
	localparam int BIT_PIN_B_EDGE_LSB = 2;
	localparam int BIT_PIN_A_EDGE_LSB = 0;
	localparam int BIT_SHARED_GROUP0_FLAG = 6;
	localparam int BIT_COMPARATOR_IRQ_FLAG = 5;
	localparam int BIT_PIN_A_IRQ_FLAG = 4;
	localparam int BIT_GLOBAL_IRQ_ENABLE = 0;
	localparam int BIT_SUPPLY_IRQ_FLAG = 4;
	localparam int BIT_SUPPLY_IRQ_ENABLE = 0;

	// writable bits per register; everything else reads zero except the live status bit 5 of the monitor register
	localparam logic [7:0] WMASK_MON = 8'h17;
	localparam logic [7:0] WMASK_EDGE = 8'h0F;
	localparam logic [7:0] WMASK_PRI0 = 8'h7F;
	localparam logic [7:0] WMASK_PRI = 8'hFF;
	localparam logic [7:0] WMASK_GRP02 = 8'h33;
	localparam logic [7:0] WMASK_GRP1 = 8'hFF;
	localparam logic [7:0] REG_RESET = 8'h00;

	// ----------------------------------------------------------------
	// edge select encodings
	// ----------------------------------------------------------------
	localparam logic [1:0] EDGE_OFF = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLOCK_MHZ = 100;
	localparam int MONITOR_IRQ_DELAY_NS = 10000;
	localparam int MONITOR_IRQ_DELAY_CYC = (MONITOR_IRQ_DELAY_NS * CLOCK_MHZ + 999) / 1000;

	// one-cycle event pulses from the peripherals
	typedef struct packed {
		logic comparator;
		logic converter;
		logic time_base_0;
		logic time_base_1;
		logic serial_if;
		logic uart;
		logic eeprom;
		logic stm_period;
		logic stm_compare;
		logic ctm_period;
		logic ctm_compare;
		logic ptm_period;
		logic ptm_compare;
	} periph_events_t;

endpackage

// file: core/irq_ctrl.sv
// interrupt flag and enable logic with supply monitor and external pins
// ----------------------------------------------------------------
// Overview of operation
// RULE1: three-bit threshold select, eight levels
// RULE2: status bit 5 follows supply below threshold
// RULE3: monitor runs only when bit 4 set
// RULE4: sleep mode disables the monitor
// RULE5: software waits for monitor to settle
// RULE6: software tolerates status chatter near threshold
// RULE7: supply flag set after fixed delay
// RULE8: set supply flag wakes from idle
// RULE9: supply interrupt goes through shared group 2
// RULE10: monitor control bits 7, 6, 3 read zero
// RULE11: two-bit edge select per pin
// RULE12: pin b field 3:2, pin a 1:0
// RULE13: edge select upper nibble reads zero
// RULE14: trigger sets flag; each source has enable
// RULE15: three shared groups with summary flag, enable
// RULE16: full set of peripheral and pin sources
// RULE17: primary register 0 bit layout
// RULE18: comparator flag gated by its enable
// RULE19: primary register 0 bit 7 reads zero
// RULE20: flag kept when disabled, no request raised
// RULE21: global enable low blocks all requests
// RULE22: service entry clears global enable
// RULE23: supply flag bit 4, enable bit 0
// RULE24: summary flag set from enabled sub-flags
// RULE25: pins synchronised, one flag per edge
// ----------------------------------------------------------------
//
// The implementer's own choices: the Wishbone register port and the register addresses.
`timescale 1ns/1ps

// three-stage synchroniser; output moves only when stages two and three agree
module sync3
(
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// async level in, filtered level out
	input wire logic async_in,
	output logic level_o
);
	logic s1_r;
	logic s2_r;
	logic s3_r;

	// first stage feeds only the second
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
		end
		else
		begin
			s1_r <= async_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// agreement gate keeps a single glitchy sample from counting
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			level_o <= 1'b0;
		else if (s2_r == s3_r)
			level_o <= s3_r;
	end
endmodule

module irq_ctrl
(
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// wishbone classic slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [4:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// supply monitor analog side
	input wire logic supply_below,
	output logic [2:0] threshold_select,
	output logic supply_monitor_power,
	// external interrupt pins
	input wire logic ext_pin_a,
	input wire logic ext_pin_b,
	// peripheral events and power modes
	input wire irq_pkg::periph_events_t events,
	input wire logic sleep_mode,
	input wire logic idle_mode,
	// processor core side
	input wire logic irq_taken,
	output logic irq_req,
	output logic wake_req
);
	logic [7:0] regs_r [irq_pkg::REG_COUNT];
	logic [7:0] regs_nxt [irq_pkg::REG_COUNT];
	logic [7:0] set_vec [irq_pkg::REG_COUNT];
	logic [7:0] wmask [irq_pkg::REG_COUNT];
	logic bus_hit;
	logic bus_wr;
	logic [2:0] bus_idx;
	logic [31:0] rd_data;
	logic supply_low_sync;
	logic pin_a_sync;
	logic pin_b_sync;
	logic pin_a_prev_r;
	logic pin_b_prev_r;
	logic pin_a_hit;
	logic pin_b_hit;
	logic monitor_active;
	logic low_status;
	logic [10:0] delay_cnt_r;
	logic monitor_fire;
	logic [2:0] grp_sum;
	logic pri_pending;
	logic any_flag;

	// ----------------------------------------------------------------
	// synchronisers and pin edge detection
	// ----------------------------------------------------------------
	sync3 u_sync_supply (.clock(clock), .rst(rst), .async_in(supply_below),
		.level_o(supply_low_sync));
	sync3 u_sync_pin_a (.clock(clock), .rst(rst), .async_in(ext_pin_a),
		.level_o(pin_a_sync)); // [RULE25]
	sync3 u_sync_pin_b (.clock(clock), .rst(rst), .async_in(ext_pin_b),
		.level_o(pin_b_sync)); // [RULE25]

	// previous filtered pin levels for edge detection
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			pin_a_prev_r <= 1'b0;
			pin_b_prev_r <= 1'b0;
		end
		else
		begin
			pin_a_prev_r <= pin_a_sync;
			pin_b_prev_r <= pin_b_sync;
		end
	end

	// edge decode per select field
	function automatic logic edge_hit(input logic [1:0] sel, input logic now, input logic prev);
		logic rise;
		logic fall;
		rise = now & ~prev;
		fall = ~now & prev;
		case (sel)
			irq_pkg::EDGE_OFF: edge_hit = 1'b0;
			irq_pkg::EDGE_RISE: edge_hit = rise;
			irq_pkg::EDGE_FALL: edge_hit = fall;
			irq_pkg::EDGE_BOTH: edge_hit = rise | fall;
			default: edge_hit = 1'b0;
		endcase
	endfunction

	// each filtered edge lasts one cycle, so each sets the flag once
	assign pin_a_hit = edge_hit(regs_r[irq_pkg::IDX_EDGE][irq_pkg::BIT_PIN_A_EDGE_LSB +: 2],
		pin_a_sync, pin_a_prev_r); // [RULE11] [RULE12]
	assign pin_b_hit = edge_hit(regs_r[irq_pkg::IDX_EDGE][irq_pkg::BIT_PIN_B_EDGE_LSB +: 2],
		pin_b_sync, pin_b_prev_r); // [RULE11] [RULE12]

	// ----------------------------------------------------------------
	// supply monitor
	// ----------------------------------------------------------------
	// status is meaningless while powered down, so it is forced low
	assign monitor_active = regs_r[irq_pkg::IDX_MON][irq_pkg::BIT_SUPPLY_MONITOR_ON]
		& ~sleep_mode; // [RULE3] [RULE4]
	assign low_status = monitor_active & supply_low_sync; // [RULE2]

	// delay from status high to flag; restarts whenever status drops
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			delay_cnt_r <= 11'h000;
		else if (!low_status)
			delay_cnt_r <= 11'h000;
		else if (delay_cnt_r != 11'(irq_pkg::MONITOR_IRQ_DELAY_CYC))
			delay_cnt_r <= delay_cnt_r + 11'h001; // [RULE7]
	end

	// single pulse when the count is reached
	assign monitor_fire = low_status
		& (delay_cnt_r == 11'(irq_pkg::MONITOR_IRQ_DELAY_CYC - 1)); // [RULE7]

	// analog controls from flops
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			threshold_select <= 3'h0;
			supply_monitor_power <= 1'b0;
		end
		else
		begin
			threshold_select <= regs_r[irq_pkg::IDX_MON][irq_pkg::BIT_THRESHOLD_LSB +: 3]; // [RULE1]
			supply_monitor_power <= monitor_active; // [RULE3] [RULE4]
		end
	end

	// ----------------------------------------------------------------
	// flag set sources
	// ----------------------------------------------------------------
	// group summary: any sub-flag whose enable is high
	always_comb
	begin
		grp_sum[0] = |(regs_r[irq_pkg::IDX_GRP0][7:4] & regs_r[irq_pkg::IDX_GRP0][3:0]);
		grp_sum[1] = |(regs_r[irq_pkg::IDX_GRP1][7:4] & regs_r[irq_pkg::IDX_GRP1][3:0]);
		grp_sum[2] = |(regs_r[irq_pkg::IDX_GRP2][7:4] & regs_r[irq_pkg::IDX_GRP2][3:0]); // [RULE24]
	end

	// hardware set vectors, flags in the upper nibble
	always_comb
	begin
		set_vec[irq_pkg::IDX_MON] = 8'h00;
		set_vec[irq_pkg::IDX_EDGE] = 8'h00;
		set_vec[irq_pkg::IDX_PRI0] = {1'b0, grp_sum[0], events.comparator, pin_a_hit, 4'h0}; // [RULE17] [RULE18]
		set_vec[irq_pkg::IDX_PRI1] = {events.time_base_0, events.converter, grp_sum[2],
			grp_sum[1], 4'h0}; // [RULE15]
		set_vec[irq_pkg::IDX_PRI2] = {events.uart, events.serial_if, pin_b_hit,
			events.time_base_1, 4'h0}; // [RULE16]
		set_vec[irq_pkg::IDX_GRP0] = {2'h0, events.stm_compare, events.stm_period, 4'h0};
		set_vec[irq_pkg::IDX_GRP1] = {events.ctm_compare, events.ctm_period, events.ptm_compare,
			events.ptm_period, 4'h0};
		set_vec[irq_pkg::IDX_GRP2] = {2'h0, events.eeprom, monitor_fire, 4'h0}; // [RULE9] [RULE23]
	end

	// writable bits; unimplemented bits stay zero
	always_comb
	begin
		wmask[irq_pkg::IDX_MON] = irq_pkg::WMASK_MON; // [RULE10]
		wmask[irq_pkg::IDX_EDGE] = irq_pkg::WMASK_EDGE; // [RULE13]
		wmask[irq_pkg::IDX_PRI0] = irq_pkg::WMASK_PRI0; // [RULE19]
		wmask[irq_pkg::IDX_PRI1] = irq_pkg::WMASK_PRI;
		wmask[irq_pkg::IDX_PRI2] = irq_pkg::WMASK_PRI;
		wmask[irq_pkg::IDX_GRP0] = irq_pkg::WMASK_GRP02;
		wmask[irq_pkg::IDX_GRP1] = irq_pkg::WMASK_GRP1;
		wmask[irq_pkg::IDX_GRP2] = irq_pkg::WMASK_GRP02;
	end

	// ----------------------------------------------------------------
	// wishbone slave
	// ----------------------------------------------------------------
	assign bus_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign bus_wr = bus_hit & wb_we_i & wb_sel_i[0];
	assign bus_idx = wb_adr_i[4:2];

	// next register values; a hardware set wins over a software clear
	always_comb
	begin
		for (int i = 0; i < irq_pkg::REG_COUNT; i++)
		begin
			regs_nxt[i] = regs_r[i];
			if (bus_wr && bus_idx == 3'(i))
				regs_nxt[i] = wb_dat_i[7:0] & wmask[i];
			regs_nxt[i] = regs_nxt[i] | set_vec[i]; // [RULE14] [RULE20]
		end
		// entering service drops the global enable, flags keep recording
		if (irq_taken)
			regs_nxt[irq_pkg::IDX_PRI0][irq_pkg::BIT_GLOBAL_IRQ_ENABLE] = 1'b0; // [RULE22]
	end

	// register file
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			for (int i = 0; i < irq_pkg::REG_COUNT; i++)
				regs_r[i] <= irq_pkg::REG_RESET;
		end
		else
		begin
			for (int i = 0; i < irq_pkg::REG_COUNT; i++)
				regs_r[i] <= regs_nxt[i];
		end
	end

	// read mux; status bit is live, not stored
	always_comb
	begin
		rd_data = 32'h0000_0000;
		rd_data[7:0] = regs_r[bus_idx];
		if (bus_idx == 3'(irq_pkg::IDX_MON))
			rd_data[irq_pkg::BIT_LOW_SUPPLY_STATUS] = low_status; // [RULE2]
	end

	// one-cycle ack, then a gap before the next request
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end
		else
		begin
			wb_ack_o <= bus_hit;
			wb_dat_o <= bus_hit ? rd_data : 32'h0000_0000;
		end
	end

	// ----------------------------------------------------------------
	// request to the core and wake-up
	// ----------------------------------------------------------------
	assign pri_pending =
		|(regs_r[irq_pkg::IDX_PRI0][6:4] & regs_r[irq_pkg::IDX_PRI0][3:1])
		| |(regs_r[irq_pkg::IDX_PRI1][7:4] & regs_r[irq_pkg::IDX_PRI1][3:0])
		| |(regs_r[irq_pkg::IDX_PRI2][7:4] & regs_r[irq_pkg::IDX_PRI2][3:0]); // [RULE18] [RULE20]

	assign any_flag = |regs_r[irq_pkg::IDX_PRI0][6:4] | |regs_r[irq_pkg::IDX_PRI1][7:4]
		| |regs_r[irq_pkg::IDX_PRI2][7:4] | |regs_r[irq_pkg::IDX_GRP0][7:4]
		| |regs_r[irq_pkg::IDX_GRP1][7:4] | |regs_r[irq_pkg::IDX_GRP2][7:4];

	// request dropped at once on service entry to avoid a double take
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			irq_req <= 1'b0;
			wake_req <= 1'b0;
		end
		else
		begin
			irq_req <= regs_r[irq_pkg::IDX_PRI0][irq_pkg::BIT_GLOBAL_IRQ_ENABLE]
				& pri_pending & ~irq_taken; // [RULE21]
			wake_req <= idle_mode & any_flag; // [RULE8]
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	sequence s_low_held;
		low_status [*8];
	endsequence

	a_sleep_powers_down: assert property (sleep_mode |=> !supply_monitor_power) // [RULE4]
		else $error("monitor powered during sleep");
	a_monitor_off_status: assert property (!monitor_active |-> !low_status) // [RULE3]
		else $error("status high with monitor off");
	a_no_early_flag: assert property (s_low_held |-> delay_cnt_r >= 11'h007 // [RULE7]
		&& delay_cnt_r <= 11'(irq_pkg::MONITOR_IRQ_DELAY_CYC))
		else $error("delay counter off track");
	a_fire_sets_flag: assert property (monitor_fire |=>
		regs_r[irq_pkg::IDX_GRP2][irq_pkg::BIT_SUPPLY_IRQ_FLAG]) // [RULE7]
		else $error("supply flag not set after delay");
	a_fire_needs_count: assert property (monitor_fire |->
		$past(low_status) && delay_cnt_r != 11'h000) // [RULE7]
		else $error("supply flag fired without delay");
	a_global_blocks: assert property
		(!regs_r[irq_pkg::IDX_PRI0][irq_pkg::BIT_GLOBAL_IRQ_ENABLE] |=> !irq_req) // [RULE21]
		else $error("request with global enable low");
	a_taken_clears: assert property (irq_taken |=>
		!regs_r[irq_pkg::IDX_PRI0][irq_pkg::BIT_GLOBAL_IRQ_ENABLE] && !irq_req) // [RULE22]
		else $error("global enable survived service entry");
	a_pin_a_sets: assert property (pin_a_hit |=> regs_r[irq_pkg::IDX_PRI0][irq_pkg::BIT_PIN_A_IRQ_FLAG]) // [RULE25]
		else $error("pin a edge lost");
	a_edge_off_quiet: assert property
		(regs_r[irq_pkg::IDX_EDGE][1:0] == irq_pkg::EDGE_OFF |-> !pin_a_hit) // [RULE11]
		else $error("pin a edge while disabled");
	a_reserved_zero: assert property (regs_r[irq_pkg::IDX_PRI0][7] == 1'b0
		&& regs_r[irq_pkg::IDX_EDGE][7:4] == 4'h0 && regs_r[irq_pkg::IDX_MON][7:5] == 3'h0) // [RULE19]
		else $error("reserved bit set");
	a_group_summary: assert property (grp_sum[2] |=>
		regs_r[irq_pkg::IDX_PRI1][5]) // [RULE24]
		else $error("group 2 summary not raised");
	a_idle_wake: assert property (idle_mode
		&& regs_r[irq_pkg::IDX_GRP2][irq_pkg::BIT_SUPPLY_IRQ_FLAG] |=> wake_req) // [RULE8]
		else $error("no wake from supply flag");
	a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held two cycles");
endmodule

// file: verification/core_model.sv
// processor core stand-in that enters service a few cycles after a request
`timescale 1ns/1ps
module core_model
#(
	parameter int RESP = 2
)
(
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// request in, service entry out
	input wire logic irq_req,
	output logic irq_taken
);
	logic [7:0] wait_r;

	// count a standing request, take it once, re-arm only after the pulse
	// so a request still high in the pulse cycle is not taken twice
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			wait_r <= 8'h00;
			irq_taken <= 1'b0;
		end
		else if (irq_taken)
		begin
			wait_r <= 8'h00;
			irq_taken <= 1'b0;
		end
		else if (irq_req)
		begin
			if (wait_r == 8'(RESP))
				irq_taken <= 1'b1;
			else
				wait_r <= wait_r + 8'h01;
		end
	end
endmodule

// file: verification/interrupt_ctrl_with_lvd_source_tb.sv
// self-checking bench for the interrupt controller with supply monitor
`timescale 1ns/1ps
module interrupt_ctrl_with_lvd_source_tb;
	logic clock, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [4:0] wb_adr_i;
	logic [31:0] wb_dat_i, wb_dat_o;
	logic [3:0] wb_sel_i;
	logic supply_below, supply_monitor_power, ext_pin_a, ext_pin_b;
	logic sleep_mode, idle_mode, irq_taken, irq_req, wake_req;
	logic [2:0] threshold_select;
	irq_pkg::periph_events_t events;
	logic [7:0] rd;
	int error_cnt, tests_run;

	irq_ctrl dut_u (.clock(clock), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .supply_below(supply_below),
		.threshold_select(threshold_select), .supply_monitor_power(supply_monitor_power),
		.ext_pin_a(ext_pin_a), .ext_pin_b(ext_pin_b), .events(events),
		.sleep_mode(sleep_mode), .idle_mode(idle_mode), .irq_taken(irq_taken),
		.irq_req(irq_req), .wake_req(wake_req));

	core_model #(.RESP(2)) core_u (.clock(clock), .rst(rst), .irq_req(irq_req),
		.irq_taken(irq_taken));

	// ----------------------------------------------------------------
	// clock and helpers
	// ----------------------------------------------------------------
	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		begin
			tests_run++;
			if (got !== exp)
			begin
				$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
				error_cnt++;
			end
		end
	endtask

	// one classic cycle; request held until ack is sampled high at a rising edge
	task automatic bus(input logic we, input logic [4:0] adr, input logic [7:0] wd,
		input logic [3:0] sel);
		int n;
		begin
			n = 0;
			@(posedge clock);
			wb_cyc_i <= 1'b1;
			wb_stb_i <= 1'b1;
			wb_we_i <= we;
			wb_adr_i <= adr;
			wb_dat_i <= {24'h000000, wd};
			wb_sel_i <= sel;
			do
			begin
				@(posedge clock);
				n++;
			end
			while (wb_ack_o !== 1'b1);
			// ack comes one cycle after the edge that takes the request
			chk(8'(n), 8'h02);
			rd = wb_dat_o[7:0];
			wb_cyc_i <= 1'b0;
			wb_stb_i <= 1'b0;
			wb_we_i <= 1'b0;
		end
	endtask

	task automatic wr(input logic [4:0] adr, input logic [7:0] wd);
		bus(1'b1, adr, wd, 4'hF);
	endtask

	task automatic rchk(input logic [4:0] adr, input logic [7:0] exp);
		begin
			bus(1'b0, adr, 8'h00, 4'hF);
			chk(rd, exp);
		end
	endtask

	task automatic ticks(input int n);
		repeat (n) @(posedge clock);
	endtask

	// groups first: summary flags re-arm while an enabled sub-flag stays set
	task automatic clear_all;
		for (int i = 7; i >= 0; i--)
			wr(5'(i * 4), 8'h00);
	endtask

	task automatic pin_set(input int p, input logic v);
		if (p == 1)
			ext_pin_b <= v;
		else
			ext_pin_a <= v;
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_regs;
		begin
			for (int i = 0; i < 8; i++)
				rchk(5'(i * 4), 8'h00);
			wr(5'h00, 8'hFF);
			rchk(5'h00, 8'h17);
			wr(5'h04, 8'hFF);
			rchk(5'h04, 8'h0F);
			wr(5'h14, 8'hFF);
			rchk(5'h14, 8'h33);
			wr(5'h08, 8'hFE);
			rchk(5'h08, 8'h7E);
			bus(1'b1, 5'h04, 8'h00, 4'h0);
			rchk(5'h04, 8'h0F);
			for (int i = 0; i < 8; i++)
			begin
				wr(5'h00, 8'(i));
				ticks(2);
				chk({5'h00, threshold_select}, 8'(i));
			end
			clear_all;
			$display("test regs done");
		end
	endtask

	task automatic t_pins;
		logic [4:0] fa;
		logic [7:0] fm;
		begin
			for (int p = 0; p < 2; p++)
				for (int c = 0; c < 4; c++)
				begin
					fa = (p == 1) ? 5'h10 : 5'h08;
					fm = (p == 1) ? 8'h20 : 8'h10;
					wr(5'h04, 8'(c << (2 * p)));
					pin_set(p, 1'b1);
					ticks(6);
					rchk(fa, (c & 1) ? fm : 8'h00);
					wr(fa, 8'h00);
					ticks(6);
					rchk(fa, 8'h00);
					pin_set(p, 1'b0);
					ticks(6);
					rchk(fa, (c & 2) ? fm : 8'h00);
					wr(fa, 8'h00);
				end
			wr(5'h04, 8'h00);
			$display("test pins done");
		end
	endtask

	task automatic t_irq;
		int n;
		begin
			events.comparator <= 1'b1;
			ticks(1);
			events <= '0;
			ticks(1);
			rchk(5'h08, 8'h20);
			wr(5'h08, 8'h21);
			ticks(3);
			chk({7'h00, irq_req}, 8'h00);
			wr(5'h08, 8'h24);
			ticks(3);
			chk({7'h00, irq_req}, 8'h00);
			wr(5'h08, 8'h25);
			ticks(1);
			chk({7'h00, irq_req}, 8'h01);
			n = 0;
			while (irq_taken !== 1'b1 && n < 20)
			begin
				@(negedge clock);
				n++;
			end
			chk({7'h00, irq_taken}, 8'h01);
			ticks(2);
			chk({7'h00, irq_req}, 8'h00);
			rchk(5'h08, 8'h24);
			wr(5'h08, 8'h00);
			$display("test irq done");
		end
	endtask

	// every peripheral source at once, then a mid-run reset back to zero
	task automatic t_events;
		begin
			events <= '1;
			ticks(1);
			events <= '0;
			rchk(5'h08, 8'h20);
			rchk(5'h0C, 8'hC0);
			rchk(5'h10, 8'hD0);
			rchk(5'h14, 8'h30);
			rchk(5'h18, 8'hF0);
			rchk(5'h1C, 8'h20);
			wr(5'h18, 8'hF1);
			rchk(5'h0C, 8'hD0);
			rst <= 1'b1;
			ticks(2);
			rst <= 1'b0;
			for (int i = 0; i < 8; i++)
				rchk(5'(i * 4), 8'h00);
			$display("test events done");
		end
	endtask

	task automatic t_supply;
		begin
			wr(5'h1C, 8'h01);
			supply_below <= 1'b1;
			wr(5'h00, 8'h13);
			ticks(6);
			rchk(5'h00, 8'h33);
			chk({7'h00, supply_monitor_power}, 8'h01);
			sleep_mode <= 1'b1;
			ticks(3);
			rchk(5'h00, 8'h13);
			chk({7'h00, supply_monitor_power}, 8'h00);
			sleep_mode <= 1'b0;
			ticks(950);
			rchk(5'h1C, 8'h01);
			ticks(60);
			rchk(5'h1C, 8'h11);
			rchk(5'h0C, 8'h20);
			idle_mode <= 1'b1;
			ticks(3);
			chk({7'h00, wake_req}, 8'h01);
			idle_mode <= 1'b0;
			// chatter near the threshold: short high stretches raise no flag
			wr(5'h1C, 8'h01);
			supply_below <= 1'b0;
			ticks(10);
			supply_below <= 1'b1;
			ticks(500);
			supply_below <= 1'b0;
			ticks(10);
			supply_below <= 1'b1;
			ticks(500);
			rchk(5'h1C, 8'h01);
			wr(5'h00, 8'h03);
			ticks(3);
			rchk(5'h00, 8'h03);
			chk({7'h00, supply_monitor_power}, 8'h00);
			supply_below <= 1'b0;
			clear_all;
			$display("test supply done");
		end
	endtask

	task automatic test_done;
		begin
			$display("checks %0d mismatches %0d", tests_run, error_cnt);
			if (error_cnt == 0 && tests_run > 0)
				$display("Regression OK");
			else
				$display("Regression broken");
			$finish;
		end
	endtask

	// ----------------------------------------------------------------
	// main sequence and watchdog
	// ----------------------------------------------------------------
	initial
	begin
		rst = 1'b1;
		{wb_cyc_i, wb_stb_i, wb_we_i, supply_below, ext_pin_a, ext_pin_b} = 6'h00;
		{sleep_mode, idle_mode} = 2'h0;
		wb_adr_i = 5'h00;
		wb_dat_i = 32'h00000000;
		wb_sel_i = 4'h0;
		events = '0;
		error_cnt = 0;
		tests_run = 0;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		t_regs;
		t_pins;
		t_irq;
		t_events;
		t_supply;
		test_done;
	end

	// whole run is a few thousand cycles; far beyond that means a hang
	initial
	begin
		repeat (20000) @(posedge clock);
		error_cnt++;
		$display("[ERR] t=%0t got=%h exp=%h", $time, 8'h00, 8'h01);
		test_done;
	end
endmodule
